// File: dv/tb_call_gate_unit.sv
// self-checking testbench of the call gate transfer unit
`timescale 1ns/1ns
module tb_call_gate_unit;
    import gate_pkg::*;
    logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, irq, err, conf, jump_instruction, inw;
    logic [1:0] current_privilege_level, requestor_privilege_level, gd, td;
    logic [2:0] es;
    logic [15:0] sel;
    logic [31:0] gof, base;
    logic [31:0] stk [6];
    int mismatches = 0, n_checks = 0, cyc = 0;
    call_gate_unit #(.MEM_DEPTH(64)) u_dut (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
    initial forever #20 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 40000) begin
            mismatches++;
            $display("mismatch at %0t: timeout", $time);
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task run(input logic j);
        apb(1'b1, OFF_CTRL, {30'h0, j, 1'b1});
        ce <= 1'b0;
        repeat (1 + $urandom % 3) @(posedge pclk);
        ce <= 1'b1;
        for (int i = 0; i < 80; i++) begin
            apb(1'b0, OFF_STATUS, 32'h0);
            if (rd[2:0] != 3'h0) break;
        end
    endtask
    function automatic logic [2:0] exp_st(logic [1:0] c, r, g, t, logic cf, jp);
        if (c > g || r > g || t > c || (!cf && jp && t != c)) return 3'h2;
        return 3'h1;
    endfunction
    task setup(input logic [31:0] gate, input logic [2:0] tgt);
        apb(1'b1, OFF_CPL, {30'h0, current_privilege_level});
        apb(1'b1, OFF_FARSEL, {16'h0, sel[15:2], requestor_privilege_level});
        apb(1'b1, OFF_GATE, gate);
        apb(1'b1, OFF_GATE_OFF, gof);
        apb(1'b1, OFF_TGT, {29'h0, tgt});
        apb(1'b1, OFF_TGT_BASE, base);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(69887));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, OFF_STATE, 32'h0);
        chk(rd, 32'h0, "idle state after reset");
        apb(1'b0, 8'h64, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped read");
        apb(1'b1, OFF_TSS_LIMIT, 32'h0000_0068);
        apb(1'b1, OFF_DT_LIMIT, 32'h0000_FFFF);
        for (int t = 0; t < 48; t++) begin
            {current_privilege_level, requestor_privilege_level, gd, td, conf, jump_instruction} = 10'($urandom);
            sel = 16'($urandom);
            gof = $urandom;
            base = $urandom;
            setup({8'h00, 1'b1, gd, 5'h00, sel}, {conf, td});
            run(jump_instruction);
            es = exp_st(current_privilege_level, requestor_privilege_level, gd, td, conf, jump_instruction);
            chk({29'h0, rd[2:0]}, {29'h0, es}, "status");
            inw = es == 3'h1 && !conf && !jump_instruction && td < current_privilege_level;
            apb(1'b0, OFF_CPL, 32'h0);
            chk(rd, {30'h0, inw ? td : current_privilege_level}, "level");
            if (es == 3'h1) begin
                apb(1'b0, OFF_ENTRY, 32'h0);
                chk(rd, base + gof, "entry");
            end
            apb(1'b1, OFF_STATUS, 32'h7);
        end
        $display("random gate checks done");
        {current_privilege_level, requestor_privilege_level, sel, gof, base} = {2'h3, 2'h3, 16'h0010, 32'h0500, 32'h1000};
        stk = '{32'h2B, 32'h40, 32'hB2, 32'hA1, 32'h1B, 32'h1234};
        apb(1'b1, OFF_TSS_SS1, 32'h23);
        apb(1'b1, OFF_TSS_SP1, 32'h80);
        apb(1'b1, OFF_SS, 32'h2B);
        apb(1'b1, OFF_SP, 32'h40);
        apb(1'b1, OFF_CS, 32'h1B);
        apb(1'b1, OFF_EIP, 32'h1234);
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, OFF_MEM_IDX, 32'(16 + k));
            apb(1'b1, OFF_MEM_DATA, k ? 32'hB2 : 32'hA1);
        end
        setup({8'h00, 1'b1, 2'h3, 5'h02, sel}, 3'h1);
        run(1'b0);
        apb(1'b0, OFF_SS, 32'h0);
        chk(rd, 32'h23, "new stack selector");
        apb(1'b0, OFF_SP, 32'h0);
        chk(rd, 32'h68, "new stack pointer");
        for (int k = 0; k < 6; k++) begin
            apb(1'b1, OFF_MEM_IDX, 32'(31 - k));
            apb(1'b0, OFF_MEM_DATA, 32'h0);
            chk(rd, stk[k], "stack word");
        end
        apb(1'b0, OFF_CS, 32'h0);
        chk(rd, 32'h10, "code selector");
        apb(1'b0, OFF_EIP, 32'h0);
        chk(rd, 32'h500, "entry pointer");
        apb(1'b0, OFF_TSS_SP1, 32'h0);
        chk(rd, 32'h80, "initial pointer kept");
        $display("inward call done");
        apb(1'b1, OFF_STATUS, 32'h7);
        apb(1'b1, OFF_MASK, 32'h4);
        apb(1'b1, OFF_TSS_LIMIT, 32'h10);
        setup({8'h00, 1'b1, 2'h3, 5'h02, sel}, 3'h1);
        run(1'b0);
        chk({29'h0, rd[2:0]}, 32'h4, "task state fault");
        chk({31'h0, irq}, 32'h1, "irq raised");
        apb(1'b0, OFF_CPL, 32'h0);
        chk(rd, 32'h3, "level kept on fault");
        apb(1'b1, OFF_MASK, 32'h0);
        chk({31'h0, irq}, 32'h0, "irq masked");
        apb(1'b1, OFF_STATUS, 32'h7);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(rd, 32'h0, "status cleared");
        $display("fault and interrupt done");
        report_and_stop();
    end
endmodule // tb_call_gate_unit

// File: pkg/gate_pkg.sv
// constants, types and register map of the call gate transfer unit
package gate_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_MASK = 8'h08;
    localparam logic [7:0] OFF_FARSEL = 8'h0C;
    localparam logic [7:0] OFF_GATE = 8'h10;
    localparam logic [7:0] OFF_GATE_OFF = 8'h14;
    localparam logic [7:0] OFF_TGT = 8'h18;
    localparam logic [7:0] OFF_TGT_BASE = 8'h1C;
    localparam logic [7:0] OFF_TSS_LIMIT = 8'h20;
    localparam logic [7:0] OFF_DT_LIMIT = 8'h24;
    localparam logic [7:0] OFF_TSS_SS0 = 8'h28;
    localparam logic [7:0] OFF_TSS_SS1 = 8'h2C;
    localparam logic [7:0] OFF_TSS_SS2 = 8'h30;
    localparam logic [7:0] OFF_TSS_SP0 = 8'h34;
    localparam logic [7:0] OFF_TSS_SP1 = 8'h38;
    localparam logic [7:0] OFF_TSS_SP2 = 8'h3C;
    localparam logic [7:0] OFF_CPL = 8'h40;
    localparam logic [7:0] OFF_CS = 8'h44;
    localparam logic [7:0] OFF_EIP = 8'h48;
    localparam logic [7:0] OFF_SS = 8'h4C;
    localparam logic [7:0] OFF_SP = 8'h50;
    localparam logic [7:0] OFF_ENTRY = 8'h54;
    localparam logic [7:0] OFF_MEM_IDX = 8'h58;
    localparam logic [7:0] OFF_MEM_DATA = 8'h5C;
    localparam logic [7:0] OFF_STATE = 8'h60;

    // field positions
    localparam int CTRL_START = 0;
    localparam int CTRL_JUMP = 1;
    localparam int ST_DONE = 0;
    localparam int ST_GP = 1;
    localparam int ST_TS = 2;
    localparam int STATE_BUSY = 4;

    // reset values
    localparam logic [1:0] CPL_RST = 2'h0;
    localparam logic [15:0] SEL_RST = 16'h0000;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    localparam logic [2:0] STAT_RST = 3'h0;

    // task state layout and descriptor size
    localparam logic [31:0] TSS_SP_BASE = 32'h0000_0004;
    localparam logic [31:0] TSS_STRIDE = 32'h0000_0008;
    localparam logic [31:0] TSS_SS_LAST = 32'h0000_0005;
    localparam logic [2:0] DESC_LAST = 3'h7;
    localparam logic [1:0] LEVEL_APP = 2'h3;
    localparam logic [31:0] ITEM32 = 32'h0000_0004;
    localparam logic [31:0] ITEM16 = 32'h0000_0002;
    localparam logic [31:0] MASK16 = 32'h0000_FFFF;

    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_CHECK = 4'h1,
        S_SWITCH = 4'h3,
        S_PUSH_SS = 4'h2,
        S_PUSH_SP = 4'h6,
        S_COPY = 4'h7,
        S_PUSH_CS = 4'h5,
        S_PUSH_IP = 4'h4,
        S_FINISH = 4'hC
    } gate_state_e;

    // gate descriptor as held in its register
    typedef struct packed {
        logic size32;
        logic [1:0] descriptor_privilege_level;
        logic [4:0] pcount;
        logic [15:0] sel;
    } gate_s;

    // target code segment attributes
    typedef struct packed {
        logic conforming;
        logic [1:0] descriptor_privilege_level;
    } target_s;

endpackage

// File: rtl/call_gate_unit.sv
// call gate privilege check, stack switch and entry unit with apb registers
//
// Overview of operation
// RULE1: a gated far pointer uses its selector only; the pointer offset is ignored
// RULE2: entry address is target segment base plus the gate offset
// RULE3: current level must not exceed the gate level, call or jump
// RULE4: selector requestor level must not exceed the gate level
// RULE5: target level is compared only after both gate checks pass
// RULE6: call to nonconforming target accepts target level at most current level
// RULE7: jump to nonconforming target needs target level equal to current level
// RULE8: conforming target: level at most current, level kept, no stack switch
// RULE9: inward call to nonconforming target lowers level and switches stacks
// RULE10: level-3 stack lives in stack registers; task state pointers are read only
// RULE11: new stack pair is picked from task state by the target level
// RULE12: limit violation fetching stack selector, pointer or descriptor raises task fault
// RULE13: old stack pair is held, new pair loaded, old pair pushed
// RULE14: copy gate parameter count items from old stack, none when zero
// RULE15: push return code selector and pointer, then load gate selector and offset
// RULE16: never enter level 3 from a more privileged level
// RULE17: software provides big enough writable stacks
// RULE18: copied items and pushes are 16 or 32 bits by gate size
// RULE19: any failed privilege check aborts with a protection fault, state unchanged
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module call_gate_unit
    import gate_pkg::*;
#(
    parameter int MEM_DEPTH = 64
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);

    localparam int MAW = $clog2(MEM_DEPTH);

    generate
        if (MEM_DEPTH < 2 || (1 << MAW) != MEM_DEPTH) begin : g_bad_depth
            $error("MEM_DEPTH must be a power of two of at least 2");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////////////////
    // state
    gate_state_e state_ff;
    logic jump_ff;
    logic [15:0] farsel_ff;
    gate_s gate_ff;
    logic [31:0] gate_off_ff;
    target_s tgt_ff;
    logic [31:0] tgt_base_ff;
    logic [31:0] tss_limit_ff;
    logic [31:0] dt_limit_ff;
    logic [15:0] tss_ss_ff [3];
    logic [31:0] tss_sp_ff [3];
    logic [1:0] cpl_ff;
    logic [15:0] cs_ff;
    logic [31:0] eip_ff;
    logic [15:0] ss_ff;
    logic [31:0] sp_ff;
    logic [31:0] entry_ff;
    logic [15:0] old_ss_ff;
    logic [31:0] old_sp_ff;
    logic [4:0] cnt_ff;
    logic [MAW-1:0] mem_idx_ff;
    logic [31:0] mem_ff [MEM_DEPTH];
    logic [2:0] status_ff;
    logic [2:0] mask_ff;
    logic [31:0] rdata_ff;
    logic rvld_ff;
    logic err_ff;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [31:0] item_bytes(input logic s32);
        return s32 ? ITEM32 : ITEM16;
    endfunction

    function automatic logic [MAW-1:0] slot(input logic [31:0] p, input logic s32);
        logic [31:0] w;
        w = s32 ? (p >> 2) : (p >> 1);
        return w[MAW-1:0];
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return (a <= OFF_STATE) && (a[1:0] == 2'h0);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////////
    // apb slave
    logic setup;
    logic wr_en;
    logic idle;
    logic start;
    logic [31:0] rd_mux;

    assign setup = psel && !penable;
    assign pready = penable && rvld_ff && ce;
    assign pslverr = pready && err_ff;
    assign prdata = rdata_ff;
    assign wr_en = psel && penable && pready && pwrite && !err_ff;
    assign idle = (state_ff == S_IDLE);
    assign start = wr_en && idle && (paddr == OFF_CTRL) && pwdata[CTRL_START];

    always_comb begin
        rd_mux = WORD_RST;
        if (paddr == OFF_CTRL) begin
            rd_mux = {30'h0000_0000, jump_ff, 1'b0};
        end else if (paddr == OFF_STATUS) begin
            rd_mux = {29'h0000_0000, status_ff};
        end else if (paddr == OFF_MASK) begin
            rd_mux = {29'h0000_0000, mask_ff};
        end else if (paddr == OFF_FARSEL) begin
            rd_mux = {16'h0000, farsel_ff};
        end else if (paddr == OFF_GATE) begin
            rd_mux = {8'h00, gate_ff};
        end else if (paddr == OFF_GATE_OFF) begin
            rd_mux = gate_off_ff;
        end else if (paddr == OFF_TGT) begin
            rd_mux = {29'h0000_0000, tgt_ff};
        end else if (paddr == OFF_TGT_BASE) begin
            rd_mux = tgt_base_ff;
        end else if (paddr == OFF_TSS_LIMIT) begin
            rd_mux = tss_limit_ff;
        end else if (paddr == OFF_DT_LIMIT) begin
            rd_mux = dt_limit_ff;
        end else if (paddr == OFF_TSS_SS0) begin
            rd_mux = {16'h0000, tss_ss_ff[0]};
        end else if (paddr == OFF_TSS_SS1) begin
            rd_mux = {16'h0000, tss_ss_ff[1]};
        end else if (paddr == OFF_TSS_SS2) begin
            rd_mux = {16'h0000, tss_ss_ff[2]};
        end else if (paddr == OFF_TSS_SP0) begin
            rd_mux = tss_sp_ff[0];
        end else if (paddr == OFF_TSS_SP1) begin
            rd_mux = tss_sp_ff[1];
        end else if (paddr == OFF_TSS_SP2) begin
            rd_mux = tss_sp_ff[2];
        end else if (paddr == OFF_CPL) begin
            rd_mux = {30'h0000_0000, cpl_ff};
        end else if (paddr == OFF_CS) begin
            rd_mux = {16'h0000, cs_ff};
        end else if (paddr == OFF_EIP) begin
            rd_mux = eip_ff;
        end else if (paddr == OFF_SS) begin
            rd_mux = {16'h0000, ss_ff};
        end else if (paddr == OFF_SP) begin
            rd_mux = sp_ff;
        end else if (paddr == OFF_ENTRY) begin
            rd_mux = entry_ff;
        end else if (paddr == OFF_MEM_IDX) begin
            rd_mux = 32'(mem_idx_ff);
        end else if (paddr == OFF_MEM_DATA) begin
            rd_mux = mem_ff[mem_idx_ff];
        end else if (paddr == OFF_STATE) begin
            rd_mux = {27'h0000_000, !idle, state_ff};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_ff <= WORD_RST;
            rvld_ff <= 1'b0;
            err_ff <= 1'b0;
        end else if (ce) begin
            if (setup) begin
                rdata_ff <= pwrite ? WORD_RST : rd_mux;
                err_ff <= !mapped(paddr);
                rvld_ff <= 1'b1;
            end else if (pready) begin
                rvld_ff <= 1'b0;
            end
        end
    end

    // request and task state registers, written by software only while idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            jump_ff <= 1'b0;
            farsel_ff <= SEL_RST;
            gate_ff <= '0;
            gate_off_ff <= WORD_RST;
            tgt_ff <= '0;
            tgt_base_ff <= WORD_RST;
            tss_limit_ff <= WORD_RST;
            dt_limit_ff <= WORD_RST;
            tss_ss_ff <= '{default: SEL_RST};
            tss_sp_ff <= '{default: WORD_RST};
            mem_idx_ff <= '0;
        end else if (ce && wr_en && idle) begin
            if (paddr == OFF_CTRL) begin
                jump_ff <= pwdata[CTRL_JUMP];
            end else if (paddr == OFF_FARSEL) begin
                farsel_ff <= pwdata[15:0]; // RULE1
            end else if (paddr == OFF_GATE) begin
                gate_ff <= pwdata[23:0];
            end else if (paddr == OFF_GATE_OFF) begin
                gate_off_ff <= pwdata;
            end else if (paddr == OFF_TGT) begin
                tgt_ff <= pwdata[2:0];
            end else if (paddr == OFF_TGT_BASE) begin
                tgt_base_ff <= pwdata;
            end else if (paddr == OFF_TSS_LIMIT) begin
                tss_limit_ff <= pwdata;
            end else if (paddr == OFF_DT_LIMIT) begin
                dt_limit_ff <= pwdata;
            end else if (paddr == OFF_TSS_SS0) begin
                tss_ss_ff[0] <= pwdata[15:0];
            end else if (paddr == OFF_TSS_SS1) begin
                tss_ss_ff[1] <= pwdata[15:0];
            end else if (paddr == OFF_TSS_SS2) begin
                tss_ss_ff[2] <= pwdata[15:0];
            end else if (paddr == OFF_TSS_SP0) begin
                tss_sp_ff[0] <= pwdata;
            end else if (paddr == OFF_TSS_SP1) begin
                tss_sp_ff[1] <= pwdata;
            end else if (paddr == OFF_TSS_SP2) begin
                tss_sp_ff[2] <= pwdata;
            end else if (paddr == OFF_MEM_IDX) begin
                mem_idx_ff <= pwdata[MAW-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // privilege checks
    logic [1:0] tdpl;
    logic gate_ok;
    logic tgt_ok;
    logic need_sw;
    logic ts_fault;
    logic [31:0] tss_sp_off;
    logic [15:0] new_ss;
    logic [31:0] new_sp;
    logic [31:0] isz;
    logic [31:0] nsp;
    logic [31:0] push_val;
    logic [31:0] parm_addr;
    logic [31:0] entry_w;
    logic pushing;

    assign tdpl = tgt_ff.descriptor_privilege_level;
    assign gate_ok = (cpl_ff <= gate_ff.descriptor_privilege_level) // RULE3
        && (farsel_ff[1:0] <= gate_ff.descriptor_privilege_level); // RULE4
    always_comb begin
        if (tgt_ff.conforming) begin
            tgt_ok = (tdpl <= cpl_ff); // RULE8
        end else if (jump_ff) begin
            tgt_ok = (tdpl == cpl_ff); // RULE7
        end else begin
            tgt_ok = (tdpl <= cpl_ff) // RULE6
                && !(tdpl == LEVEL_APP && cpl_ff != LEVEL_APP); // RULE16
        end
    end
    assign need_sw = !jump_ff && !tgt_ff.conforming && (tdpl < cpl_ff); // RULE9

    // new stack fetch and its limit checks
    assign tss_sp_off = TSS_SP_BASE + TSS_STRIDE * 32'(tdpl); // RULE11
    assign new_ss = tss_ss_ff[tdpl]; // RULE10 RULE11
    assign new_sp = tss_sp_ff[tdpl];
    assign ts_fault = (tss_sp_off + TSS_SS_LAST > tss_limit_ff) // RULE12
        || ({16'h0000, new_ss[15:3], DESC_LAST} > dt_limit_ff);

    // push data path, sized by the gate
    assign isz = item_bytes(gate_ff.size32); // RULE18
    assign nsp = sp_ff - isz;
    assign parm_addr = old_sp_ff + 32'(cnt_ff - 5'h01) * isz;
    assign entry_w = tgt_base_ff + gate_off_ff; // RULE2
    always_comb begin
        case (state_ff)
            S_PUSH_SS: push_val = {16'h0000, old_ss_ff};
            S_PUSH_SP: push_val = old_sp_ff;
            S_COPY: push_val = mem_ff[slot(parm_addr, gate_ff.size32)]; // RULE14
            S_PUSH_CS: push_val = {16'h0000, cs_ff};
            S_PUSH_IP: push_val = eip_ff;
            default: push_val = WORD_RST;
        endcase
        if (!gate_ff.size32) begin
            push_val = push_val & MASK16; // RULE18
        end
    end
    assign pushing = (state_ff == S_PUSH_SS) || (state_ff == S_PUSH_SP) || (state_ff == S_COPY)
        || (state_ff == S_PUSH_CS) || (state_ff == S_PUSH_IP);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= S_IDLE;
            cnt_ff <= 5'h00;
            old_ss_ff <= SEL_RST;
            old_sp_ff <= WORD_RST;
        end else if (ce) begin
            case (state_ff)
                S_IDLE: begin
                    if (start) begin
                        state_ff <= S_CHECK;
                    end
                end
                S_CHECK: begin
                    if (!gate_ok || !tgt_ok) begin // RULE5 RULE19
                        state_ff <= S_IDLE;
                    end else if (need_sw) begin
                        state_ff <= S_SWITCH;
                    end else if (jump_ff) begin
                        state_ff <= S_FINISH;
                    end else begin
                        state_ff <= S_PUSH_CS; // RULE8
                    end
                end
                S_SWITCH: begin
                    if (ts_fault) begin // RULE12
                        state_ff <= S_IDLE;
                    end else begin
                        old_ss_ff <= ss_ff; // RULE13
                        old_sp_ff <= sp_ff;
                        cnt_ff <= gate_ff.pcount;
                        state_ff <= S_PUSH_SS;
                    end
                end
                S_PUSH_SS: state_ff <= S_PUSH_SP;
                S_PUSH_SP: state_ff <= (cnt_ff == 5'h00) ? S_PUSH_CS : S_COPY; // RULE14
                S_COPY: begin
                    cnt_ff <= cnt_ff - 5'h01;
                    if (cnt_ff == 5'h01) begin
                        state_ff <= S_PUSH_CS;
                    end
                end
                S_PUSH_CS: state_ff <= S_PUSH_IP; // RULE15
                S_PUSH_IP: state_ff <= S_FINISH;
                default: state_ff <= S_IDLE;
            endcase
        end
    end

    // architectural registers: software while idle, sequencer otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpl_ff <= CPL_RST;
            cs_ff <= SEL_RST;
            eip_ff <= WORD_RST;
            ss_ff <= SEL_RST;
            sp_ff <= WORD_RST;
            entry_ff <= WORD_RST;
        end else if (ce) begin
            if (wr_en && idle) begin
                if (paddr == OFF_CPL) begin
                    cpl_ff <= pwdata[1:0];
                end else if (paddr == OFF_CS) begin
                    cs_ff <= pwdata[15:0];
                end else if (paddr == OFF_EIP) begin
                    eip_ff <= pwdata;
                end else if (paddr == OFF_SS) begin
                    ss_ff <= pwdata[15:0];
                end else if (paddr == OFF_SP) begin
                    sp_ff <= pwdata;
                end
            end else if (state_ff == S_SWITCH && !ts_fault) begin
                ss_ff <= new_ss; // RULE13
                sp_ff <= new_sp;
            end else if (pushing) begin
                sp_ff <= nsp;
            end else if (state_ff == S_FINISH) begin
                cs_ff <= gate_ff.sel; // RULE15
                eip_ff <= gate_off_ff;
                entry_ff <= entry_w; // RULE2
                if (need_sw) begin
                    cpl_ff <= tdpl; // RULE9
                end
            end
        end
    end

    // stack memory
    always_ff @(posedge pclk) begin
        if (ce) begin
            if (pushing) begin
                mem_ff[slot(nsp, gate_ff.size32)] <= push_val; // RULE13 RULE15
            end else if (wr_en && idle && paddr == OFF_MEM_DATA) begin
                mem_ff[mem_idx_ff] <= pwdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // events and interrupt
    logic [2:0] ev;
    logic [2:0] w1c;

    assign ev[ST_DONE] = (state_ff == S_FINISH);
    assign ev[ST_GP] = (state_ff == S_CHECK) && (!gate_ok || !tgt_ok); // RULE19
    assign ev[ST_TS] = (state_ff == S_SWITCH) && ts_fault; // RULE12
    assign w1c = (wr_en && paddr == OFF_STATUS) ? pwdata[2:0] : 3'h0;
    assign irq = |(status_ff & mask_ff);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_ff <= STAT_RST;
            mask_ff <= STAT_RST;
        end else if (ce) begin
            status_ff <= (status_ff & ~w1c) | ev;
            if (wr_en && paddr == OFF_MASK) begin
                mask_ff <= pwdata[2:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge pclk iff ce);
    endclocking
    default disable iff (!presetn);

    sequence s_check;
        state_ff == S_CHECK;
    endsequence
    sequence s_good_switch;
        state_ff == S_SWITCH && !ts_fault;
    endsequence
    sequence s_old_pair;
        state_ff == S_PUSH_SS ##1 state_ff == S_PUSH_SP;
    endsequence

    gate_check_a: assert property (s_check and !gate_ok // RULE3
        |=> idle && status_ff[ST_GP] && $stable(cpl_ff) && $stable(sp_ff))
        else $error("gate check fail not aborted");
    rpl_check_a: assert property (s_check and farsel_ff[1:0] > gate_ff.descriptor_privilege_level // RULE4
        |=> idle && status_ff[ST_GP])
        else $error("requestor level not checked");
    jump_equal_a: assert property (s_check and jump_ff && !tgt_ff.conforming // RULE7
        && tdpl != cpl_ff |=> status_ff[ST_GP] && $stable(cs_ff))
        else $error("jump level mismatch accepted");
    call_inward_a: assert property (s_check and gate_ok && !jump_ff // RULE9
        && !tgt_ff.conforming && tdpl < cpl_ff |=> state_ff == S_SWITCH)
        else $error("inward call no switch");
    conform_keep_a: assert property (s_check and tgt_ff.conforming && gate_ok // RULE8
        && tdpl <= cpl_ff |-> !ev[ST_GP] ##1 state_ff != S_SWITCH)
        else $error("conforming mishandled");
    tss_fault_a: assert property (state_ff == S_SWITCH && ts_fault // RULE12
        |=> idle && status_ff[ST_TS] && $stable(ss_ff))
        else $error("task fault not raised");
    stack_load_a: assert property (s_good_switch // RULE13
        |=> ss_ff == $past(new_ss) && old_sp_ff == $past(sp_ff) ##0 s_old_pair)
        else $error("stack switch order");
    copy_count_a: assert property (state_ff == S_PUSH_SP && cnt_ff == 5'h02 // RULE14
        |=> (state_ff == S_COPY)[*2] ##1 state_ff == S_PUSH_CS)
        else $error("copy count");
    no_copy_a: assert property (state_ff == S_PUSH_SP && cnt_ff == 5'h00 // RULE14
        |=> state_ff == S_PUSH_CS)
        else $error("copied with zero count");
    entry_load_a: assert property (state_ff == S_FINISH // RULE15
        |=> eip_ff == $past(gate_off_ff) && entry_ff == $past(entry_w) && idle)
        else $error("entry not loaded");

endmodule // call_gate_unit
